// >>> rtl/adc_seq_cfg.svh
// constants for the sweep sequencer: register offsets, field positions, timing
// assumes inclusion by bare name from rtl and sim files
`ifndef ADC_SEQ_CFG_SVH
`define ADC_SEQ_CFG_SVH
`define CTRL_OFS 4'h0
`define STAT_OFS 4'h1
`define RES_OFS 4'h8
`define CTRL_START_BIT 0
`define CTRL_TRIG_SRC_BIT 1
`define CTRL_HWSEL_LO_BIT 2
`define CTRL_HWSEL_HI_BIT 3
`define CTRL_MODE_LO_BIT 4
`define CTRL_MODE_HI_BIT 5
`define CTRL_WIDTH_LO_BIT 6
`define CTRL_WIDTH_HI_BIT 7
`define CTRL_GROUP_LO_BIT 8
`define CTRL_GROUP_HI_BIT 9
`define CTRL_SS_TMR_EN_BIT 10
`define CTRL_RESET 32'h0000_0000
`define CONV_TIME_NS 1000
`define CLK_PERIOD_NS 40
`define CONV_CYCLES ((`CONV_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// >>> rtl/adc_seq_pkg.sv
// types shared by the sweep sequencer files
// assumes nothing beyond a SystemVerilog compiler
package adc_seq_pkg;
  typedef enum logic [1:0] {mode_single, mode_sim_sample, mode_delay0, mode_rsvd} sweep_mode_t;
  typedef enum logic [1:0] {hw_ext_pin, hw_alt_timer, hw_freq_counter, hw_rsvd} hw_trig_t;
  typedef enum logic [2:0] {st_idle, st_sample, st_convert, st_wait_delay, st_done} seq_state_t;
endpackage

// >>> rtl/adc_sweep_trigger_sequencer.sv
// sweep and delayed-trigger sequencer of a multi-channel converter
// assumes timer underflows are one-cycle pulses on clk_i; the trigger pin
// and the converter data come from outside and are sampled here
//
// Local design decisions: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ns
`include "adc_seq_cfg.svh"

// Summary of operation
// [RQ1] convert selected inputs one after another
// [RQ2] channels 0 and 1 sampled together
// [RQ3] software trigger: start bit write starts
// [RQ4] hardware trigger chosen by select bits
// [RQ5] pin falling edge starts once armed
// [RQ6] timer underflow starts once start bit set
// [RQ7] stop at sweep end, clear start bit (code clears it only for software trigger outside delay mode)
// [RQ8] writing zero to start halts conversion
// [RQ9] interrupt request at sequence completion
// [RQ10] widths: 2, 4, 6 or 8 channels
// [RQ11] software keeps sweep within one group
// [RQ12] each result in its own register
// [RQ13] sweep-start timer adds to simultaneous triggers
// [RQ14] delay mode: channel 1 waits delay timer
// [RQ15] repeat start before delay is ignored
// [RQ16] start during channel 1+ restarts sweep
// [RQ17] early delay samples channel 1 immediately
// [RQ18] delay mode stops after one sweep
// [RQ19] software never sets start in delay mode
// [RQ20] software loads delay timer larger
module adc_sweep_trigger_sequencer
  import adc_seq_pkg::*;
#(
  parameter int RES_W = 10,
  parameter int CHANS = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic external_trigger_pin_i,
  input wire logic sweep_start_timer_uf_i,
  input wire logic delay_timer_uf_i,
  input wire logic alt_trigger_timer_uf_i,
  input wire logic freq_counter_uf_i,
  input wire logic [RES_W-1:0] conv_data_i,
  output logic sample_ch0_o,
  output logic sample_ch1_o,
  output logic [2:0] conv_channel_o,
  output logic [1:0] input_group_o,
  output logic converting_o,
  output logic conv_irq_o
);
  localparam int CW = $clog2(CHANS);
  // conversion time fixed at build; one counter serves every channel
  localparam logic [7:0] CONV_N = 8'(`CONV_CYCLES);

  logic [31:0] ctrl_reg;
  logic [2:0] pin_sync_reg;
  logic pin_level_reg;
  logic pin_fall;
  seq_state_t state_reg;
  logic [CW-1:0] chan_reg;
  logic [7:0] cnt_reg;
  logic ch1_held_reg;
  logic done_pulse;
  logic res_we;
  logic rd_pend_reg;
  logic rd_res_reg;
  logic [31:0] rd_ctrl_reg;
  logic [RES_W-1:0] res_data;
  logic start_bit;
  logic trig_src;
  hw_trig_t hw_sel;
  sweep_mode_t mode;
  logic [1:0] width_sel;
  logic [CW-1:0] last_chan;
  logic hw_trig;
  logic start_req;
  logic wr_ctrl;
  logic sw_halt;
  logic early_ch1;
  logic restart_ok;

  assign start_bit = ctrl_reg[`CTRL_START_BIT];
  assign trig_src = ctrl_reg[`CTRL_TRIG_SRC_BIT];
  assign hw_sel = hw_trig_t'(ctrl_reg[`CTRL_HWSEL_HI_BIT:`CTRL_HWSEL_LO_BIT]);
  assign mode = sweep_mode_t'(ctrl_reg[`CTRL_MODE_HI_BIT:`CTRL_MODE_LO_BIT]);
  assign width_sel = ctrl_reg[`CTRL_WIDTH_HI_BIT:`CTRL_WIDTH_LO_BIT];
  // 00..11 -> last channel 1, 3, 5, 7
  assign last_chan = CW'({width_sel, 1'b1}); // [RQ10]
  assign input_group_o = ctrl_reg[`CTRL_GROUP_HI_BIT:`CTRL_GROUP_LO_BIT]; // [RQ11]

  // trigger pin: three flops, change counts when second and third agree
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pin_sync_reg <= 3'h7;
      pin_level_reg <= 1'b1;
    end
    else
    begin
      pin_sync_reg <= {pin_sync_reg[1:0], external_trigger_pin_i};
      if (pin_sync_reg[1] == pin_sync_reg[2])
      begin
        pin_level_reg <= pin_sync_reg[2];
      end
    end
  end
  assign pin_fall = pin_level_reg && (pin_sync_reg[1] == pin_sync_reg[2]) && !pin_sync_reg[2];

  always_comb
  begin
    unique case (hw_sel) // [RQ4]
      hw_ext_pin: hw_trig = pin_fall; // [RQ5]
      hw_alt_timer: hw_trig = alt_trigger_timer_uf_i; // [RQ6]
      hw_freq_counter: hw_trig = freq_counter_uf_i; // [RQ6]
      hw_rsvd: hw_trig = 1'b0;
    endcase
  end

  // outside delay mode, hardware triggers only count while the start bit is already armed
  assign wr_ctrl = avs_write && (avs_address == `CTRL_OFS);
  // a zero write halts in every mode, delay mode included
  assign sw_halt = wr_ctrl && !avs_writedata[`CTRL_START_BIT]; // [RQ8]
  always_comb
  begin
    start_req = 1'b0;
    if (mode == mode_delay0)
    begin
      start_req = sweep_start_timer_uf_i; // [RQ14]
    end
    else if (!trig_src)
    begin
      start_req = wr_ctrl && avs_writedata[`CTRL_START_BIT] && !start_bit; // [RQ3]
    end
    else if (start_bit)
    begin
      start_req = hw_trig || (mode == mode_sim_sample && ctrl_reg[`CTRL_SS_TMR_EN_BIT]
        && sweep_start_timer_uf_i); // [RQ13]
    end
  end

  // delay underflow while channel 0 converts: sample channel 1 now
  assign early_ch1 = (mode == mode_delay0) && delay_timer_uf_i && (state_reg == st_convert)
    && (chan_reg == '0); // [RQ17]

  // delay mode restarts only once channel 1 or a later one has begun
  assign restart_ok = (state_reg == st_idle) || (state_reg == st_done)
    || (mode == mode_delay0 && chan_reg != '0 && state_reg != st_wait_delay); // [RQ15] [RQ16]

  // control register; a software write wins over the hardware start clear
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl_reg <= `CTRL_RESET;
    end
    else if (wr_ctrl)
    begin
      ctrl_reg <= avs_writedata;
    end
    else if (done_pulse && !trig_src && mode != mode_delay0)
    begin
      ctrl_reg[`CTRL_START_BIT] <= 1'b0; // [RQ7]
    end
  end

  // sequencer
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_reg <= st_idle;
      chan_reg <= '0;
      cnt_reg <= 8'h00;
      ch1_held_reg <= 1'b0;
    end
    else if (sw_halt)
    begin
      state_reg <= st_idle; // [RQ8]
      ch1_held_reg <= 1'b0;
    end
    else if (start_req && restart_ok)
    begin
      // idle start, or delay-mode restart from channel 0 mid-sweep
      state_reg <= st_sample; // [RQ16]
      chan_reg <= '0;
      cnt_reg <= 8'h00;
      ch1_held_reg <= 1'b0;
    end
    else
    begin
      // a start pulse while channel 0 runs or waits falls through here [RQ15]
      if (early_ch1)
      begin
        ch1_held_reg <= 1'b1; // [RQ17]
      end
      unique case (state_reg)
        st_idle:
        begin
          cnt_reg <= 8'h00;
        end
        st_sample:
        begin
          state_reg <= st_convert;
          cnt_reg <= 8'h00;
        end
        st_convert:
        begin
          if (cnt_reg == CONV_N - 8'h01)
          begin
            cnt_reg <= 8'h00;
            if (chan_reg == last_chan)
            begin
              state_reg <= st_done; // [RQ18]
            end
            else if (mode == mode_delay0 && chan_reg == '0
              && !ch1_held_reg && !delay_timer_uf_i)
            begin
              state_reg <= st_wait_delay; // [RQ14]
              chan_reg <= chan_reg + CW'(1);
            end
            else
            begin
              chan_reg <= chan_reg + CW'(1); // [RQ1]
              // channel 1 was held with channel 0 or early: no new sample
              state_reg <= (chan_reg == '0 && mode != mode_single) ? st_convert : st_sample;
            end
          end
          else
          begin
            cnt_reg <= cnt_reg + 8'h01;
          end
        end
        st_wait_delay:
        begin
          // only the delay underflow moves on; start pulses are ignored
          if (delay_timer_uf_i)
          begin
            state_reg <= st_sample; // [RQ14]
          end
        end
        st_done:
        begin
          // one cycle only: it is the irq pulse and the start-bit clear
          state_reg <= st_idle;
        end
      endcase
    end
  end

  assign done_pulse = (state_reg == st_done);
  assign res_we = (state_reg == st_convert) && (cnt_reg == CONV_N - 8'h01);
  assign converting_o = (state_reg == st_sample) || (state_reg == st_convert);
  assign conv_irq_o = done_pulse; // [RQ9]

  // sample strobes: sim mode holds ch0 and ch1 together [RQ2]
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sample_ch0_o <= 1'b0;
      sample_ch1_o <= 1'b0;
      conv_channel_o <= 3'h0;
    end
    else
    begin
      sample_ch0_o <= (state_reg == st_sample) && chan_reg == '0;
      sample_ch1_o <= ((state_reg == st_sample) && ((chan_reg == '0 && mode == mode_sim_sample)
        || (chan_reg == CW'(1)))) || early_ch1; // [RQ2] [RQ17]
      conv_channel_o <= 3'(chan_reg);
    end
  end

  // results held per channel [RQ12]
  result_mem #(
    .WIDTH(RES_W),
    .DEPTH(CHANS)
  ) u_result_mem (
    .clk_i(clk_i),
    .wr_en_i(res_we),
    .wr_addr_i(chan_reg),
    .wr_data_i(conv_data_i),
    .rd_addr_i(avs_address[CW-1:0]),
    .rd_data_o(res_data)
  );

  // bus: writes done in one cycle, reads wait one cycle for memory data
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rd_pend_reg <= 1'b0;
      rd_res_reg <= 1'b0;
      rd_ctrl_reg <= 32'h0000_0000;
    end
    else
    begin
      rd_pend_reg <= avs_read && !rd_pend_reg;
      rd_res_reg <= avs_address >= `RES_OFS;
      unique case (avs_address)
        `CTRL_OFS: rd_ctrl_reg <= ctrl_reg;
        `STAT_OFS: rd_ctrl_reg <= {26'h0, converting_o, state_reg == st_wait_delay,
          1'b0, 3'(chan_reg)};
        default: rd_ctrl_reg <= 32'h0000_0000;
      endcase
    end
  end
  assign avs_waitrequest = avs_read && !rd_pend_reg;
  assign avs_readdata = rd_res_reg ? 32'(res_data) : rd_ctrl_reg;
endmodule

// >>> rtl/result_mem.sv
// per-channel conversion result store with registered read data
// assumes one writer and one reader on clk_i
`timescale 1ns/1ns
module result_mem #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 8
) (
  input wire logic clk_i,
  input wire logic wr_en_i,
  input wire logic [$clog2(DEPTH)-1:0] wr_addr_i,
  input wire logic [WIDTH-1:0] wr_data_i,
  input wire logic [$clog2(DEPTH)-1:0] rd_addr_i,
  output logic [WIDTH-1:0] rd_data_o
);
  logic [WIDTH-1:0] mem_reg [DEPTH];

  always_ff @(posedge clk_i)
  begin
    if (wr_en_i)
    begin
      mem_reg[wr_addr_i] <= wr_data_i;
    end
  end

  always_ff @(posedge clk_i)
  begin
    rd_data_o <= mem_reg[rd_addr_i];
  end
endmodule

// >>> sim/adc_seq_monitor.sv
// assertions on the sequencer ports
// assumes one clock and the synchronous reset of the block
`timescale 1ns/1ns
`include "adc_seq_cfg.svh"
module adc_seq_monitor (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [3:0] avs_address,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic sample_ch0_o,
  input wire logic sample_ch1_o,
  input wire logic [2:0] conv_channel_o,
  input wire logic [1:0] input_group_o,
  input wire logic converting_o,
  input wire logic conv_irq_o
);
  logic [31:0] ctrl_reg;
  // shadow of the control word; write wins over self-clear
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl_reg <= `CTRL_RESET;
    end
    else if (avs_write && avs_address == `CTRL_OFS)
    begin
      ctrl_reg <= avs_writedata;
    end
    else if (conv_irq_o && !ctrl_reg[`CTRL_TRIG_SRC_BIT] && ctrl_reg[5:4] != 2'h2)
    begin
      ctrl_reg[`CTRL_START_BIT] <= 1'b0;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence ctl_wr_s;
    avs_write && avs_address == `CTRL_OFS;
  endsequence
  irq_pulse_a: assert property (conv_irq_o |=> !conv_irq_o)
    else $error("irq longer than one cycle");
  group_follow_a: assert property (ctl_wr_s
    |=> input_group_o == $past(avs_writedata[9:8])) else $error("group select not applied");
  sw_start_a: assert property (ctl_wr_s ##0 (avs_writedata[5:0] == 6'h01 && !converting_o)
    |-> ##[1:3] converting_o) else $error("software start not taken");
  sw_halt_a: assert property (ctl_wr_s ##0 !avs_writedata[0]
    |-> ##[1:3] !converting_o) else $error("halt not taken");
  unarmed_idle_a: assert property (!ctrl_reg[0] && ctrl_reg[5:4] != 2'h2
    && !converting_o && !avs_write |=> !converting_o) else $error("started while unarmed");
  sweep_stop_a: assert property (conv_irq_o |-> ##[1:2] !converting_o)
    else $error("still converting after sweep end");
  width_bound_a: assert property (converting_o && $past(converting_o, 2)
    |-> conv_channel_o <= {ctrl_reg[7:6], 1'b1}) else $error("channel beyond width");
  pair_sample_a: assert property (sample_ch0_o && ctrl_reg[5:4] == 2'h1 |-> sample_ch1_o)
    else $error("channels 0 and 1 not sampled together");
endmodule
bind adc_sweep_trigger_sequencer adc_seq_monitor u_adc_seq_monitor (.clk_i, .rst_i,
  .avs_address, .avs_write, .avs_writedata, .sample_ch0_o, .sample_ch1_o,
  .conv_channel_o, .input_group_o, .converting_o, .conv_irq_o);

// >>> sim/tb_adc_sweep_trigger_sequencer.sv
// bench for the sweep sequencer: random sweeps, trigger and delay cases
// assumes the trigger model answers fire requests one cycle later
`timescale 1ns/1ns
`include "adc_seq_cfg.svh"
module tb_adc_sweep_trigger_sequencer;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [4:0] fire = 5'h0;
  logic [6:0] salt = 7'h0;
  logic [31:0] xs = 32'h46;
  logic [31:0] avs_readdata, rd, ctl;
  logic avs_waitrequest, pin, s0, s1, conv, irq;
  logic [3:0] uf;
  logic [9:0] cdata;
  logic [2:0] chan;
  logic [1:0] grp;
  int miscompares = 0;
  int check_count = 0;
  always #20 clk_i = ~clk_i;
  adc_sweep_trigger_sequencer u_adc_sweep_trigger_sequencer (.clk_i, .rst_i, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
    .external_trigger_pin_i(pin), .sweep_start_timer_uf_i(uf[0]), .delay_timer_uf_i(uf[1]),
    .alt_trigger_timer_uf_i(uf[2]), .freq_counter_uf_i(uf[3]), .conv_data_i(cdata),
    .sample_ch0_o(s0), .sample_ch1_o(s1), .conv_channel_o(chan), .input_group_o(grp),
    .converting_o(conv), .conv_irq_o(irq));
  trig_model u_trig_model (.clk_i, .fire_i(fire), .salt_i(salt), .chan_i(chan), .uf_o(uf),
    .pin_o(pin), .data_o(cdata));
  function automatic logic [31:0] rnd();
    xs = xs ^ (xs << 13);
    xs = xs ^ (xs >> 17);
    xs = xs ^ (xs << 5);
    return xs;
  endfunction
  function automatic logic [31:0] exp_res(logic [6:0] s, logic [2:0] c);
    return {22'h0, s, c};
  endfunction
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // each bus task starts one edge later, so strobes never toggle twice at once
  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= 1'b1;
    do @(posedge clk_i); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
  endtask
  task rdw(input logic [3:0] a);
    @(posedge clk_i);
    avs_address <= a;
    avs_read <= 1'b1;
    do @(posedge clk_i); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
  endtask
  task trig(input int b);
    @(posedge clk_i);
    fire <= 5'h1 << b;
    @(posedge clk_i);
    fire <= 5'h0;
  endtask
  task wait_irq;
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 1000)
    begin
      @(posedge clk_i);
      n++;
    end
    check("sweep end irq", irq, 1);
  endtask
  task sweep(input logic [1:0] w, input logic [1:0] mode);
    salt <= 7'(rnd());
    ctl = {22'h0, 2'(rnd()), w, mode, 4'h1};
    wr(`CTRL_OFS, ctl);
    wait_irq();
    rdw(`CTRL_OFS);
    check("control after sweep", rd, ctl & ~32'h1);
    for (int c = 0; c <= 2 * w + 1; c++)
    begin
      rdw(`RES_OFS + c[3:0]);
      check("result", rd, exp_res(salt, c[2:0]));
    end
  endtask
  initial
  begin
    repeat (20000) @(posedge clk_i);
    miscompares++;
    tally_and_finish();
  end
  initial
  begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    rdw(`CTRL_OFS);
    check("control reset", rd, `CTRL_RESET);
    rdw(4'h2);
    check("unmapped read", rd, 32'h0);
    for (int w = 0; w < 4; w++)
      sweep(w[1:0], {1'b0, w[0]});
    wr(`CTRL_OFS, 32'h0c1);
    repeat (30) @(posedge clk_i);
    check("running", conv, 1);
    wr(`CTRL_OFS, 32'h0c0);
    repeat (3) @(posedge clk_i);
    check("halted", conv, 0);
    for (int s = 0; s < 3; s++)
    begin
      ctl = {28'h0, s[1:0], 2'h2};
      wr(`CTRL_OFS, ctl);
      trig(s == 0 ? 4 : s + 1);
      repeat (8) @(posedge clk_i);
      check("unarmed trigger", conv, 0);
      wr(`CTRL_OFS, ctl | 32'h1);
      trig(s == 0 ? 4 : s + 1);
      wait_irq();
    end
    wr(`CTRL_OFS, 32'h413);
    trig(0);
    wait_irq();
    // delay mode leaves the start bit clear throughout
    wr(`CTRL_OFS, 32'h060);
    trig(0);
    repeat (40) @(posedge clk_i);
    trig(0);
    repeat (10) @(posedge clk_i);
    rdw(`STAT_OFS);
    check("waiting delay", rd[4], 1);
    trig(1);
    wait_irq();
    trig(0);
    repeat (40) @(posedge clk_i);
    trig(1);
    repeat (10) @(posedge clk_i);
    trig(0);
    repeat (5) @(posedge clk_i);
    rdw(`STAT_OFS);
    check("restart channel", rd[2:0], 0);
    trig(1);
    wait_irq();
    repeat (3) @(posedge clk_i);
    check("stopped", conv, 0);
    tally_and_finish();
  end
endmodule

// >>> sim/trig_model.sv
// timers, trigger pin and converter data seen by the sequencer
// assumes fire_i bits are one-cycle requests from the bench
`timescale 1ns/1ns
module trig_model (
  input wire logic clk_i,
  input wire logic [4:0] fire_i,
  input wire logic [6:0] salt_i,
  input wire logic [2:0] chan_i,
  output logic [3:0] uf_o,
  output logic pin_o,
  output logic [9:0] data_o
);
  logic [3:0] uf_q = 4'h0;
  logic [3:0] low_cnt = 4'h0;
  always_ff @(posedge clk_i)
  begin
    uf_q <= fire_i[3:0];
    low_cnt <= fire_i[4] ? 4'h8 : low_cnt - {3'h0, low_cnt != 4'h0};
  end
  // pin idles high; held low long enough for the synchroniser
  assign pin_o = (low_cnt == 4'h0);
  assign uf_o = uf_q;
  // code follows the channel so misplaced results show up
  assign data_o = {salt_i, chan_i};
endmodule
